// file: logic/cmp_ctrl_pkg.sv
/*
  Package for the dual analog comparator control block: register offsets,
  field positions, input select codes, reset values and the packed carriers
  shared by the top module and the per-comparator channel.
  Assumes a 32-bit classic Wishbone bus with byte addresses; only the low
  byte of each word holds register bits.
*/
`default_nettype none

package cmp_ctrl_pkg;

  // ---------------------------------------------------------------------
  // Register map, byte addresses
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_EDGE = 8'h04;
  localparam logic [7:0] OFS_NSEL = 8'h08;
  localparam logic [7:0] OFS_PSEL = 8'h0C;
  localparam logic [7:0] CMP_STRIDE = 8'h10;
  localparam logic [7:0] ADR_MIRROR = 8'h20;
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h24;
  localparam logic [7:0] ADR_IRQ_CLEAR = 8'h28;
  localparam logic [7:0] ADR_IRQ_ENABLE = 8'h2C;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int unsigned BIT_ENABLE = 7;
  localparam int unsigned BIT_RESULT = 6;
  localparam int unsigned BIT_POLARITY = 4;
  localparam int unsigned BIT_READ_ONE = 2;
  localparam int unsigned BIT_HYSTERESIS = 1;
  localparam int unsigned BIT_SYNC = 0;
  localparam int unsigned BIT_RISE_IE = 1;
  localparam int unsigned BIT_FALL_IE = 0;
  localparam int unsigned SEL_MSB = 2;

  // ---------------------------------------------------------------------
  // Input select codes
  // ---------------------------------------------------------------------
  localparam logic [2:0] SEL_PIN0 = 3'h0;
  localparam logic [2:0] SEL_PIN1 = 3'h1;
  localparam logic [2:0] SEL_PIN2 = 3'h2;
  localparam logic [2:0] SEL_PIN3 = 3'h3;
  localparam logic [2:0] SEL_DAC = 3'h5;
  localparam logic [2:0] SEL_FVR = 3'h6;
  localparam logic [2:0] SEL_GND = 3'h7;

  // Number of comparator instances.
  localparam int unsigned CMP_COUNT = 2;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic polarity_invert;
    logic hysteresis_enable;
    logic sync_mode;
    logic rising_edge_irq_enable;
    logic falling_edge_irq_enable;
    logic [2:0] inverting_input_select;
    logic [2:0] noninverting_input_select;
  } cmp_cfg_t;

  // Inverting route: [3:0] pins, [4] reference buffer, [5] ground.
  // Noninverting route: [0] pin 0, [1] pin 1, [2] DAC, [3] buffer, [4] ground.
  typedef struct packed {
    logic enable;
    logic hysteresis_enable;
    logic [5:0] inverting_route;
    logic [4:0] noninverting_route;
  } cmp_analog_t;

  typedef struct packed {
    logic raw_s1;
    logic raw_s2;
    logic tck_s1;
    logic tck_s2;
    logic tck_prev;
    logic result;
    logic result_prev;
    logic ext_out;
    cmp_analog_t analog;
  } ch_state_t;

  typedef struct packed {
    cmp_cfg_t [1:0] cfg;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic ack;
    logic [31:0] rdata;
    logic irq;
  } top_state_t;

  localparam cmp_cfg_t CFG_RST = '0;
  localparam ch_state_t CH_RST = '0;
  localparam top_state_t TOP_RST = '0;

endpackage : cmp_ctrl_pkg

`default_nettype wire

// file: logic/cmp_channel.sv
/*
  One comparator channel: synchronises the analog result and the Timer1
  clock source, applies enable and polarity, registers the result once per
  clock, detects edges, resamples the external output on Timer1 falling
  edges in sync mode and decodes the input routes.
  Assumes configuration comes from flip-flops on the same clock.
*/
`default_nettype none

module cmp_channel (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Configuration
  input wire cmp_ctrl_pkg::cmp_cfg_t i_cfg,
  // Analog side
  input wire logic i_analog_result,
  input wire logic i_tmr1_clk_src,
  output cmp_ctrl_pkg::cmp_analog_t o_analog,
  // Results
  output logic o_result,
  output logic o_ext_out,
  output logic o_rise,
  output logic o_fall
);

  cmp_ctrl_pkg::ch_state_t s_q;
  cmp_ctrl_pkg::ch_state_t s_d;

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.raw_s1 = i_analog_result;
    s_d.raw_s2 = s_q.raw_s1;
    s_d.tck_s1 = i_tmr1_clk_src;
    s_d.tck_s2 = s_q.tck_s1;
    s_d.tck_prev = s_q.tck_s2;
    // A disabled comparator is taken as low before polarity, so toggling enable or polarity can still make an edge.
    s_d.result = (i_cfg.enable & s_q.raw_s2) ^ i_cfg.polarity_invert; // [RQ1] [RQ2] [RQ3] [RQ15] [RQ16]
    s_d.result_prev = s_q.result; // [RQ17]
    if (!i_cfg.sync_mode) begin
      s_d.ext_out = s_d.result; // [RQ5]
    end else if (s_q.tck_prev & ~s_q.tck_s2) begin
      s_d.ext_out = s_q.result; // [RQ5]
    end
    s_d.analog.enable = i_cfg.enable; // [RQ1]
    s_d.analog.hysteresis_enable = i_cfg.hysteresis_enable; // [RQ4]
    s_d.analog.inverting_route = '0;
    s_d.analog.noninverting_route = '0;
    // Inputs stay disconnected while the comparator is off.
    if (i_cfg.enable) begin
      case (i_cfg.inverting_input_select) // [RQ9]
        cmp_ctrl_pkg::SEL_PIN0: s_d.analog.inverting_route = 6'h01;
        cmp_ctrl_pkg::SEL_PIN1: s_d.analog.inverting_route = 6'h02;
        cmp_ctrl_pkg::SEL_PIN2: s_d.analog.inverting_route = 6'h04;
        cmp_ctrl_pkg::SEL_PIN3: s_d.analog.inverting_route = 6'h08;
        cmp_ctrl_pkg::SEL_FVR: s_d.analog.inverting_route = 6'h10;
        cmp_ctrl_pkg::SEL_GND: s_d.analog.inverting_route = 6'h20;
        default: s_d.analog.inverting_route = 6'h00;
      endcase
      case (i_cfg.noninverting_input_select) // [RQ10]
        cmp_ctrl_pkg::SEL_PIN0: s_d.analog.noninverting_route = 5'h01;
        cmp_ctrl_pkg::SEL_PIN1: s_d.analog.noninverting_route = 5'h02;
        cmp_ctrl_pkg::SEL_DAC: s_d.analog.noninverting_route = 5'h04;
        cmp_ctrl_pkg::SEL_FVR: s_d.analog.noninverting_route = 5'h08;
        cmp_ctrl_pkg::SEL_GND: s_d.analog.noninverting_route = 5'h10;
        default: s_d.analog.noninverting_route = 5'h00;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= cmp_ctrl_pkg::CH_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Edge pulses last one clock, taken from the current and previous sample.
  assign o_rise = s_q.result & ~s_q.result_prev; // [RQ17]
  assign o_fall = ~s_q.result & s_q.result_prev; // [RQ17]
  assign o_result = s_q.result;
  assign o_ext_out = s_q.ext_out;
  assign o_analog = s_q.analog;

endmodule : cmp_channel

`default_nettype wire

// file: logic/cmp_ctrl_top.sv
/*
  Control and status logic for two analog comparators behind a classic
  Wishbone slave: per-comparator control, edge interrupt enable and input
  select registers, a shared result mirror and a sticky interrupt block.
  Assumes the analog comparators, the Timer1 clock source and the pins sit
  outside; the analog results and the Timer1 clock are asynchronous.
*/
// Overview of operation
// [RQ1] Enable bit 7 switches comparator on.
// [RQ2] Bit 6 reads the polarity-corrected comparator result.
// [RQ3] Polarity bit 4 inverts result everywhere downstream.
// [RQ4] Hysteresis bit 1 drives analog hysteresis enable.
// [RQ5] Sync mode updates external output on Timer1 falls.
// [RQ6] Control bit 2 reads one; 5,3 zero.
// [RQ7] Rising enable sets flag on result rise.
// [RQ8] Falling enable sets flag on result fall.
// [RQ9] Inverting select routes pins, buffer, ground, none.
// [RQ10] Noninverting select routes pins, DAC, buffer, ground.
// [RQ11] Select fields in bits 2..0, rest zero.
// [RQ12] Mirror register: comparator 2 bit 1, 1 bit 0.
// [RQ13] Two instances, each with own four registers.
// [RQ14] Flag cleared by software; simultaneous edge wins.
// [RQ15] Toggling polarity or enable while off makes edges.
// [RQ16] Internal result registered once per clock.
// [RQ17] Edge pulse from current versus previous sample.
// [RQ18] All writable fields reset to zero.
`default_nettype none

module cmp_ctrl_top (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Analog comparators and Timer1
  input wire logic [1:0] i_analog_result,
  input wire logic i_tmr1_clk_src,
  output cmp_ctrl_pkg::cmp_analog_t [1:0] o_analog,
  // Results towards Timer1 and pins
  output logic [1:0] o_cmp_out_ext,
  // Interrupt
  output logic o_irq
);

  // -------------------------------------------------------------------
  // State and channel wiring
  // -------------------------------------------------------------------
  cmp_ctrl_pkg::top_state_t s_q;
  cmp_ctrl_pkg::top_state_t s_d;

  logic [1:0] ch_result;
  logic [1:0] ch_rise;
  logic [1:0] ch_fall;

  // -------------------------------------------------------------------
  // Comparator channels
  // -------------------------------------------------------------------
  // Each instance carries its own configuration and its own analog pair.
  genvar gi;
  generate
    for (gi = 0; gi < cmp_ctrl_pkg::CMP_COUNT; gi++) begin : g_cmp // [RQ13]
      cmp_channel u_channel (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_cfg(s_q.cfg[gi]),
        .i_analog_result(i_analog_result[gi]),
        .i_tmr1_clk_src(i_tmr1_clk_src),
        .o_analog(o_analog[gi]),
        .o_result(ch_result[gi]),
        .o_ext_out(o_cmp_out_ext[gi]),
        .o_rise(ch_rise[gi]),
        .o_fall(ch_fall[gi])
      );
    end
  endgenerate

  // -------------------------------------------------------------------
  // Bus decode helpers
  // -------------------------------------------------------------------
  // A request is taken only while ack is low, so each access is acked once.
  logic bus_req;
  logic bus_wr;
  logic low_lane;
  logic in_cmp;
  logic cmp_idx;
  logic [7:0] reg_ofs;

  assign bus_req = i_wb_cyc & i_wb_stb & ~s_q.ack;
  assign bus_wr = bus_req & i_wb_we;
  assign low_lane = i_wb_sel[0];
  assign in_cmp = i_wb_adr < cmp_ctrl_pkg::ADR_MIRROR;
  assign cmp_idx = i_wb_adr[4];
  assign reg_ofs = {4'h0, i_wb_adr[3:2], 2'h0};

  // -------------------------------------------------------------------
  // Read data mux
  // -------------------------------------------------------------------
  // Unmapped addresses read as zero and are still acknowledged.
  function automatic logic [7:0] read_byte(
    input cmp_ctrl_pkg::top_state_t st,
    input logic [1:0] res,
    input logic [7:0] adr
  );
    cmp_ctrl_pkg::cmp_cfg_t c;
    logic [7:0] ofs;
    logic [7:0] v;
    c = st.cfg[adr[4]];
    ofs = {4'h0, adr[3:2], 2'h0};
    v = 8'h00;
    if (adr < cmp_ctrl_pkg::ADR_MIRROR) begin
      case (ofs)
        cmp_ctrl_pkg::OFS_CTRL: begin
          v[cmp_ctrl_pkg::BIT_ENABLE] = c.enable; // [RQ1]
          v[cmp_ctrl_pkg::BIT_RESULT] = res[adr[4]]; // [RQ2]
          v[cmp_ctrl_pkg::BIT_POLARITY] = c.polarity_invert; // [RQ3]
          v[cmp_ctrl_pkg::BIT_READ_ONE] = 1'b1; // [RQ6]
          v[cmp_ctrl_pkg::BIT_HYSTERESIS] = c.hysteresis_enable; // [RQ4]
          v[cmp_ctrl_pkg::BIT_SYNC] = c.sync_mode; // [RQ5]
        end
        cmp_ctrl_pkg::OFS_EDGE: begin
          v[cmp_ctrl_pkg::BIT_RISE_IE] = c.rising_edge_irq_enable; // [RQ7]
          v[cmp_ctrl_pkg::BIT_FALL_IE] = c.falling_edge_irq_enable; // [RQ8]
        end
        cmp_ctrl_pkg::OFS_NSEL: begin
          v[2:0] = c.inverting_input_select; // [RQ11]
        end
        cmp_ctrl_pkg::OFS_PSEL: begin
          v[2:0] = c.noninverting_input_select; // [RQ11]
        end
        default: v = 8'h00;
      endcase
    end else begin
      case (adr)
        cmp_ctrl_pkg::ADR_MIRROR: v[1:0] = res; // [RQ12]
        cmp_ctrl_pkg::ADR_IRQ_STATUS: v[1:0] = st.irq_status;
        cmp_ctrl_pkg::ADR_IRQ_ENABLE: v[1:0] = st.irq_enable;
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction : read_byte

  // -------------------------------------------------------------------
  // Edge events
  // -------------------------------------------------------------------
  // An edge only counts when its own enable is set.
  logic [1:0] edge_set;

  always_comb begin
    for (int i = 0; i < cmp_ctrl_pkg::CMP_COUNT; i++) begin
      edge_set[i] = (ch_rise[i] & s_q.cfg[i].rising_edge_irq_enable) // [RQ7]
        | (ch_fall[i] & s_q.cfg[i].falling_edge_irq_enable); // [RQ8]
    end
  end

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  // The clear mask comes from a write-one-to-clear access.
  logic [1:0] clr_mask;

  always_comb begin
    s_d = s_q;
    clr_mask = 2'h0;

    // Acknowledge one cycle after the request and drop it the next cycle.
    s_d.ack = bus_req;
    s_d.rdata = 32'h0000_0000;
    if (bus_req && !i_wb_we) begin
      s_d.rdata = {24'h00_0000, read_byte(s_q, ch_result, i_wb_adr)};
    end

    // Register writes land only through byte lane 0; other lanes hold nothing.
    if (bus_wr && low_lane) begin
      if (in_cmp) begin
        case (reg_ofs)
          cmp_ctrl_pkg::OFS_CTRL: begin
            // Result and the fixed bits are read-only and ignore writes.
            s_d.cfg[cmp_idx].enable = i_wb_dat[cmp_ctrl_pkg::BIT_ENABLE]; // [RQ1]
            s_d.cfg[cmp_idx].polarity_invert = i_wb_dat[cmp_ctrl_pkg::BIT_POLARITY]; // [RQ3]
            s_d.cfg[cmp_idx].hysteresis_enable = i_wb_dat[cmp_ctrl_pkg::BIT_HYSTERESIS]; // [RQ4]
            s_d.cfg[cmp_idx].sync_mode = i_wb_dat[cmp_ctrl_pkg::BIT_SYNC]; // [RQ5] [RQ6]
          end
          cmp_ctrl_pkg::OFS_EDGE: begin
            s_d.cfg[cmp_idx].rising_edge_irq_enable = i_wb_dat[cmp_ctrl_pkg::BIT_RISE_IE]; // [RQ7]
            s_d.cfg[cmp_idx].falling_edge_irq_enable = i_wb_dat[cmp_ctrl_pkg::BIT_FALL_IE]; // [RQ8]
          end
          cmp_ctrl_pkg::OFS_NSEL: begin
            s_d.cfg[cmp_idx].inverting_input_select = i_wb_dat[cmp_ctrl_pkg::SEL_MSB:0]; // [RQ9] [RQ11]
          end
          cmp_ctrl_pkg::OFS_PSEL: begin
            s_d.cfg[cmp_idx].noninverting_input_select = i_wb_dat[cmp_ctrl_pkg::SEL_MSB:0]; // [RQ10] [RQ11]
          end
          default: begin
            s_d.cfg = s_q.cfg;
          end
        endcase
      end else begin
        case (i_wb_adr)
          cmp_ctrl_pkg::ADR_IRQ_CLEAR: clr_mask = i_wb_dat[1:0]; // [RQ14]
          cmp_ctrl_pkg::ADR_IRQ_ENABLE: s_d.irq_enable = i_wb_dat[1:0];
          default: clr_mask = 2'h0;
        endcase
      end
    end

    // Sticky flags: a new edge in the clearing cycle keeps the flag set.
    s_d.irq_status = (s_q.irq_status & ~clr_mask) | edge_set; // [RQ14]

    // The interrupt line follows the flags that will stand next cycle.
    s_d.irq = |(s_d.irq_status & s_d.irq_enable);
  end

  // -------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------
  // Everything software can write starts at zero, comparators off.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= cmp_ctrl_pkg::TOP_RST; // [RQ18]
    end else begin
      s_q <= s_d;
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  assign o_wb_ack = s_q.ack;
  assign o_wb_dat = s_q.rdata;
  assign o_irq = s_q.irq;

endmodule : cmp_ctrl_top

`default_nettype wire

// file: tb/cmp_ctrl_top_props.sv
/*
  Checker for the comparator control block: bus answer timing, fixed read
  bits, input routes and interrupt clearing.
  Assumes it sees only the top module's ports, attached by the bind below.
*/
`default_nettype none

module cmp_ctrl_top_props (
  // Clock, reset and bus
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Analog side and interrupt
  input wire logic [1:0] i_analog_result,
  input wire logic i_tmr1_clk_src,
  input wire cmp_ctrl_pkg::cmp_analog_t [1:0] o_analog,
  input wire logic [1:0] o_cmp_out_ext,
  input wire logic o_irq
);
  // -----------------------------------------------------------------------
  // Properties
  // -----------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  // A taken request is answered on the very next cycle, for one cycle only.
  property p_ack_answer;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack not one cycle after request");
  property p_ack_pulse;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_idle;
    !o_wb_ack |-> o_wb_dat == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data not zero outside ack");

  // Control reads: bit 2 reads one, bits 5, 3 and the upper bytes zero.
  property p_ctrl_fixed;
    o_wb_ack && $past(!i_wb_we && i_wb_adr[7:5] == 3'h0 && i_wb_adr[3:2] == 2'h0)
      |-> (o_wb_dat & 32'hFFFF_FF2C) == 32'h0000_0004;
  endproperty
  a_ctrl_fixed: assert property (p_ctrl_fixed) else $error("control fixed bits wrong");
  property p_sel_zero;
    o_wb_ack && $past(!i_wb_we && i_wb_adr[7:5] == 3'h0 && i_wb_adr[3:2] != 2'h0)
      |-> (o_wb_dat & 32'hFFFF_FFF8) == 32'h0000_0000;
  endproperty
  a_sel_zero: assert property (p_sel_zero) else $error("unused select bits not zero");
  property p_mirror_zero;
    o_wb_ack && $past(!i_wb_we && i_wb_adr[7:3] == 5'h04) |-> o_wb_dat[31:2] == 30'h0;
  endproperty
  a_mirror_zero: assert property (p_mirror_zero) else $error("mirror upper bits not zero");

  // A disabled comparator 0 routes nothing; routes never select two sources.
  property p_route_off;
    !o_analog[0].enable |-> o_analog[0].inverting_route == 6'h00 && o_analog[0].noninverting_route == 5'h00;
  endproperty
  a_route_off: assert property (p_route_off) else $error("route active while disabled");
  property p_route_onehot;
    $onehot0(o_analog[0].inverting_route) && $onehot0(o_analog[0].noninverting_route)
      && $onehot0(o_analog[1].inverting_route) && $onehot0(o_analog[1].noninverting_route);
  endproperty
  a_route_onehot: assert property (p_route_onehot) else $error("two inputs routed at once");

  // The interrupt only falls after a software write.
  property p_irq_clear;
    $fell(o_irq) |-> $past(i_wb_we && i_wb_stb) || $past(i_wb_we && i_wb_stb, 2);
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt dropped without a write");

  c_write: cover property (o_wb_ack && $past(i_wb_we));
  c_irq: cover property ($rose(o_irq));
  c_ext: cover property ($fell(o_cmp_out_ext[0]));
endmodule : cmp_ctrl_top_props

bind cmp_ctrl_top cmp_ctrl_top_props i_cmp_ctrl_top_props (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_analog_result(i_analog_result),
  .i_tmr1_clk_src(i_tmr1_clk_src), .o_analog(o_analog), .o_cmp_out_ext(o_cmp_out_ext), .o_irq(o_irq));

`default_nettype wire

// file: tb/test_cmp_ctrl_top.sv
/*
  Self-checking bench for the comparator control block: register rows, a
  mid-run reset, input routes, result, interrupts and sync mode.
  Assumes the checker is bound to the top module.
*/
`default_nettype none

module test_cmp_ctrl_top;
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------------------------------------
  // Signals, rows and design
  // -----------------------------------------------------------------------
  logic clk_sys = 1'b0, reset_n = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, tmr1 = 1'b1;
  logic wb_ack, irq;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
  logic [3:0] wb_sel = 4'h0;
  logic [1:0] analog = 2'h0, ext;
  cmp_ctrl_pkg::cmp_analog_t [1:0] route;
  int num_errors = 0, check_count = 0;
  // Each row is address, write data, expected read back.
  logic [23:0] rows [10] = '{24'h04FF03, 24'h08FF07, 24'h0C0505, 24'h140202, 24'h180606,
                            24'h1CF800, 24'h2CFF03, 24'h30FF00, 24'h28FF00, 24'h20FF00};

  always #5 clk_sys = ~clk_sys;

  cmp_ctrl_top i_cmp_ctrl_top (
    .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
    .i_wb_adr(wb_adr), .i_wb_dat(wb_wdat), .i_wb_sel(wb_sel), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack),
    .i_analog_result(analog), .i_tmr1_clk_src(tmr1), .o_analog(route), .o_cmp_out_ext(ext), .o_irq(irq));

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One classic cycle; the request stays put until ack is seen at an edge.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat, input logic [3:0] sel);
    int n;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= {24'h0, dat};
    wb_sel <= sel;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) begin
      num_errors++;
      $display("Error wb ack expected 1 seen %b", wb_ack);
      summarize();
    end
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    wb(1'b1, adr, dat, 4'h1);
  endtask : wr

  task automatic rchk(input logic [7:0] adr, input logic [7:0] exp);
    wb(1'b0, adr, 8'h00, 4'hF);
    check($sformatf("reg %h", adr), {24'h0, exp}, rd);
  endtask : rchk

  task automatic ticks(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : ticks

  // Main sequence: rows first, then reset and the awkward cases.
  initial begin
    ticks(10);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rchk(rows[i][23:16], rows[i][7:0]);
    end
    reset_n <= 1'b0;
    ticks(3);
    reset_n <= 1'b1;
    for (int a = 0; a < 48; a += 4) begin
      rchk(8'(a), (a < 32 && a % 16 == 0) ? 8'h04 : 8'h00);
    end
    wb(1'b1, 8'h04, 8'h03, 4'h0);
    rchk(8'h04, 8'h00);
    // Routes follow every select code while the comparator is on.
    wr(8'h00, 8'h82);
    for (int c = 0; c < 8; c++) begin
      wr(8'h08, 8'(c));
      wr(8'h0C, 8'(c));
      ticks(2);
      check("inv route", 32'(c < 4 ? 1 << c : c == 6 ? 16 : c == 7 ? 32 : 0), 32'(route[0].inverting_route));
      check("pos route", 32'(c < 2 ? 1 << c : c > 4 ? 1 << (c - 3) : 0), 32'(route[0].noninverting_route));
    end
    check("on hys", 32'h3, 32'({route[0].enable, route[0].hysteresis_enable}));
    wr(8'h00, 8'h00);
    ticks(2);
    check("all off", 32'h0, 32'(route[0]));
    // Result, mirror and edge interrupts of comparator 1.
    wr(8'h2C, 8'h03);
    wr(8'h00, 8'h80);
    wr(8'h04, 8'h02);
    wr(8'h28, 8'h03);
    analog <= 2'b01;
    ticks(8);
    check("irq rise", 32'h1, 32'(irq));
    rchk(8'h00, 8'hC4);
    rchk(8'h20, 8'h01);
    rchk(8'h24, 8'h01);
    wr(8'h28, 8'h01);
    ticks(3);
    check("irq clear", 32'h0, 32'(irq));
    analog <= 2'b00;
    ticks(8);
    check("fall masked", 32'h0, 32'(irq));
    wr(8'h04, 8'h01);
    analog <= 2'b01;
    ticks(8);
    check("rise masked", 32'h0, 32'(irq));
    analog <= 2'b00;
    ticks(8);
    check("irq fall", 32'h1, 32'(irq));
    // Polarity flip of a disabled comparator still makes an edge.
    wr(8'h04, 8'h03);
    wr(8'h00, 8'h00);
    wr(8'h28, 8'h01);
    wr(8'h00, 8'h10);
    ticks(6);
    check("pol edge", 32'h1, 32'(irq));
    rchk(8'h20, 8'h01);
    wr(8'h10, 8'h90);
    ticks(6);
    rchk(8'h20, 8'h03);
    check("ext 2", 32'h1, 32'(ext[1]));
    check("route 2", 32'h1021, 32'(route[1]));
    analog <= 2'b10;
    ticks(6);
    rchk(8'h20, 8'h01);
    // Sync mode holds the external output until a Timer1 clock fall.
    wr(8'h00, 8'h81);
    ticks(8);
    check("sync hold", 32'h1, 32'(ext[0]));
    tmr1 <= 1'b0;
    ticks(8);
    check("sync load", 32'h0, 32'(ext[0]));
    wr(8'h00, 8'h80);
    analog <= 2'b11;
    ticks(6);
    check("ext follow", 32'h1, 32'(ext[0]));
    summarize();
  end
endmodule : test_cmp_ctrl_top

`default_nettype wire
